// ---- shared/pls_map.svh ----
// Constants for the port link and lamp status block.
// Assumes a 25 MHz clock; included by the package and design files.
//
// Overview of operation
// - The drive takes its incoming serial data from the automation-to-drive pair.
// - The drive sends its serial data on the drive-to-automation pair.
// - The network port autonegotiates its link speed with the partner.
// - Straight mode drives the first pair, crossed mode drives the second pair.
// - With both lamps, link lamp follows carrier and no carrier clears both.
// - With both lamps, the traffic lamp blinks during traffic, else stays off.
// - With only the link lamp, it is off, steady on, or blinking with traffic.
`ifndef PLS_MAP_SVH
`define PLS_MAP_SVH

// ==========================================================================
// Timing
// ==========================================================================
`define PLS_CLK_HZ       25000000
`define PLS_BLINK_HZ     4
// Half period of the blink, in clock cycles (rounded down).
`define PLS_BLINK_HALF   (`PLS_CLK_HZ / (2 * `PLS_BLINK_HZ))
`define PLS_CNT_W        22
// Autonegotiation time limit before the link is declared failed.
`define PLS_ANEG_MS      10
`define PLS_ANEG_CYC     (`PLS_ANEG_MS * (`PLS_CLK_HZ / 1000))
`define PLS_ANEG_W       18
`define PLS_ONE          22'h00_0001

`endif

// ---- shared/pls_pkg.sv ----
// Types for the port link and lamp status block.
// Assumes the constants header is in the include path.
package pls_pkg;
  `include "pls_map.svh"

  typedef enum logic [3:0]
  {
    PLS_IDLE = 4'b0001,
    PLS_NEG  = 4'b0010,
    PLS_UP   = 4'b0100,
    PLS_FAIL = 4'b1000
  } pls_aneg_t;

  typedef enum logic [1:0]
  {
    PLS_SPD_10   = 2'h0,
    PLS_SPD_100  = 2'h1,
    PLS_SPD_1000 = 2'h2
  } pls_speed_t;
endpackage

// ---- shared/pls_blink_if.sv ----
// Carries the blink request and blink phase between the top and the divider.
// Assumes one clock shared by both ends.
`timescale 1ns/100ps
interface pls_blink_if;
  logic run;
  logic phase;
  modport ctl (output run, input phase);
  modport div (input run, output phase);
endinterface

// ---- hw/pls_blink_div.sv ----
// Blink divider for the status lamps.
// Assumes synchronous active low reset from the top module.
`timescale 1ns/100ps
`include "pls_map.svh"
module pls_blink_div
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      rst_b,
  // Blink control
  pls_blink_if.div       bl
);
  import pls_pkg::*;

  logic [`PLS_CNT_W-1:0] cnt_r;
  logic [`PLS_CNT_W-1:0] cnt_nxt;
  logic                  ph_r;
  logic                  ph_nxt;

  // ========================================================================
  // Divider
  // ========================================================================
  // Counter is cleared and phase set to 1 as soon as activity drops, so no stale
  // toggle fires once the lamp has gone dark.
  always_comb
  begin
    cnt_nxt = cnt_r;
    ph_nxt  = ph_r;
    if (!bl.run)
    begin
      cnt_nxt = '0;
      ph_nxt  = 1'b1;
    end
    else if (cnt_r == `PLS_CNT_W'(`PLS_BLINK_HALF - 1))
    begin
      cnt_nxt = '0;
      ph_nxt  = ~ph_r;
    end
    else
    begin
      cnt_nxt = cnt_r + `PLS_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r <= '0;
      ph_r  <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      ph_r  <= ph_nxt;
    end
  end

  assign bl.phase = ph_r;

  // ========================================================================
  // Checks
  // ========================================================================
  idle_phase_a: assert property (@(posedge clk) disable iff (!rst_b)
    !bl.run |=> ph_r && cnt_r == '0)
    else $error("blink not reset when idle");
  cnt_bound_a: assert property (@(posedge clk) disable iff (!rst_b)
    cnt_r < `PLS_CNT_W'(`PLS_BLINK_HALF))
    else $error("blink counter out of range");
  toggle_c: cover property (@(posedge clk) disable iff (!rst_b)
    bl.run && $changed(ph_r));
endmodule

// ---- hw/pls_port_top.sv ----
// Link direction, autonegotiation and status lamps of the drive port.
// Assumes all inputs are synchronous to clk; PHY pair drive is by enables.
`timescale 1ns/100ps
`include "pls_map.svh"
module pls_port_top
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Serial port
  input  wire logic              ser_a2d_rx,
  output logic                   ser_d2a_tx,
  output logic                   ser_rx_data,
  input  wire logic              ser_tx_data,
  // Network port configuration and status
  input  wire logic              net_crossed,
  input  wire logic              net_partner_ok,
  input  wire pls_pkg::pls_speed_t net_partner_spd,
  input  wire pls_pkg::pls_speed_t net_local_max,
  input  wire logic              net_carrier,
  input  wire logic              net_tx_act,
  input  wire logic              net_rx_act,
  input  wire logic              lamp_both,
  // Network pair drive enables and link status
  output logic                   first_pair_oe,
  output logic                   second_pair_oe,
  output logic                   link_up,
  output pls_pkg::pls_speed_t    link_speed,
  // Lamps
  output logic                   link_lamp,
  output logic                   traffic_lamp
);
  import pls_pkg::*;

  // ========================================================================
  // Reset release
  // ========================================================================
  logic rs1_r;
  logic rs2_r;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end
    else
    begin
      rs1_r <= 1'b1;
      rs2_r <= rs1_r;
    end
  end
  logic srst_b;
  assign srst_b = rs2_r;

  // ========================================================================
  // Serial lanes
  // ========================================================================
  logic ser_tx_nxt;
  logic ser_rx_nxt;
  always_comb
  begin
    ser_rx_nxt = ser_a2d_rx;
    ser_tx_nxt = ser_tx_data;
  end

  // ========================================================================
  // Autonegotiation
  // ========================================================================
  function automatic pls_speed_t min_spd(input pls_speed_t a,
                                         input pls_speed_t b);
    min_spd = (a < b) ? a : b;
  endfunction

  pls_aneg_t               st_r;
  pls_aneg_t               st_nxt;
  logic [`PLS_ANEG_W-1:0]  tmr_r;
  logic [`PLS_ANEG_W-1:0]  tmr_nxt;
  pls_speed_t              spd_r;
  pls_speed_t              spd_nxt;

  // A partner that vanishes mid-link drops us back to idle; spd_r keeps the
  // last negotiated speed until the next negotiation.
  always_comb
  begin
    st_nxt  = st_r;
    tmr_nxt = tmr_r;
    spd_nxt = spd_r;
    unique case (st_r)
      PLS_IDLE:
      begin
        tmr_nxt = '0;
        if (net_carrier)
          st_nxt = PLS_NEG;
      end
      PLS_NEG:
      begin
        tmr_nxt = tmr_r + 1'b1;
        if (!net_carrier)
          st_nxt = PLS_IDLE;
        else if (net_partner_ok)
        begin
          spd_nxt = min_spd(net_partner_spd, net_local_max);
          st_nxt  = PLS_UP;
        end
        else if (tmr_r == `PLS_ANEG_W'(`PLS_ANEG_CYC - 1))
          st_nxt = PLS_FAIL;
      end
      PLS_UP:
      begin
        if (!net_carrier || !net_partner_ok)
          st_nxt = PLS_IDLE;
      end
      PLS_FAIL:
      begin
        if (!net_carrier)
          st_nxt = PLS_IDLE;
        else if (net_partner_ok)
          st_nxt = PLS_NEG;
      end
      default:
        st_nxt = PLS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r  <= PLS_IDLE;
      tmr_r <= '0;
      spd_r <= PLS_SPD_10;
    end
    else if (!srst_b)
    begin
      st_r  <= PLS_IDLE;
      tmr_r <= '0;
      spd_r <= PLS_SPD_10;
    end
    else
    begin
      st_r  <= st_nxt;
      tmr_r <= tmr_nxt;
      spd_r <= spd_nxt;
    end
  end

  // ========================================================================
  // Blink divider
  // ========================================================================
  pls_blink_if bl ();
  logic act;
  assign act = net_carrier && (net_tx_act || net_rx_act);
  assign bl.run = act;

  pls_blink_div u_div
  (
    .clk   (clk),
    .rst_b (srst_b),
    .bl    (bl)
  );

  // ========================================================================
  // Outputs
  // ========================================================================
  logic fp_nxt;
  logic sp_nxt;
  logic ll_nxt;
  logic tl_nxt;
  always_comb
  begin
    fp_nxt = !net_crossed;
    sp_nxt = net_crossed;
    if (!net_carrier)
    begin
      ll_nxt = 1'b0;
      tl_nxt = 1'b0;
    end
    else if (lamp_both)
    begin
      ll_nxt = 1'b1;
      tl_nxt = act ? bl.phase : 1'b0;
    end
    else
    begin
      ll_nxt = act ? bl.phase : 1'b1;
      tl_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ser_d2a_tx     <= 1'b1;
      ser_rx_data    <= 1'b1;
      first_pair_oe  <= 1'b0;
      second_pair_oe <= 1'b0;
      link_up        <= 1'b0;
      link_speed     <= PLS_SPD_10;
      link_lamp      <= 1'b0;
      traffic_lamp   <= 1'b0;
    end
    else
    begin
      ser_d2a_tx     <= ser_tx_nxt;
      ser_rx_data    <= ser_rx_nxt;
      first_pair_oe  <= fp_nxt;
      second_pair_oe <= sp_nxt;
      link_up        <= (st_r == PLS_UP);
      link_speed     <= spd_r;
      link_lamp      <= ll_nxt;
      traffic_lamp   <= tl_nxt;
    end
  end

  // ========================================================================
  // Checks
  // ========================================================================
  rx_lane_a: assert property (@(posedge clk) disable iff (!srst_b)
    ser_rx_data == $past(ser_a2d_rx))
    else $error("serial receive lane wrong");
  tx_lane_a: assert property (@(posedge clk) disable iff (!srst_b)
    ser_d2a_tx == $past(ser_tx_data))
    else $error("serial transmit lane wrong");
  pair_drive_a: assert property (@(posedge clk) disable iff (!srst_b)
    $past(net_crossed) |-> second_pair_oe && !first_pair_oe)
    else $error("crossed mode drives wrong pair");
  aneg_speed_a: assert property (@(posedge clk) disable iff (!srst_b)
    st_r == PLS_NEG && net_carrier && net_partner_ok
    |=> st_r == PLS_UP && spd_r <= net_local_max)
    else $error("negotiated speed above local limit");
  no_carrier_a: assert property (@(posedge clk) disable iff (!srst_b)
    !net_carrier |=> !link_lamp && !traffic_lamp)
    else $error("lamps lit without carrier");
  traffic_off_a: assert property (@(posedge clk) disable iff (!srst_b)
    !(net_tx_act || net_rx_act) |=> !traffic_lamp)
    else $error("traffic lamp lit while idle");
  single_lamp_a: assert property (@(posedge clk) disable iff (!srst_b)
    net_carrier && !lamp_both && !net_tx_act && !net_rx_act
    |=> link_lamp)
    else $error("single lamp not steady");
  link_steady_a: assert property (@(posedge clk) disable iff (!srst_b)
    net_carrier && lamp_both |=> link_lamp)
    else $error("link lamp off with carrier");
  blink_c: cover property (@(posedge clk) disable iff (!srst_b)
    lamp_both && act && traffic_lamp ##1 act && !traffic_lamp);
  up_c: cover property (@(posedge clk) disable iff (!srst_b)
    $rose(link_up));
  fail_c: cover property (@(posedge clk) disable iff (!srst_b)
    st_r == PLS_FAIL);
endmodule

// ---- sim/pls_far_model.sv ----
// Far side of the port: automation device serial lanes and Ethernet PHY.
// Assumes bench commands change after a rising edge; outputs lag a cycle.
`timescale 1ns/100ps
module pls_far_model
(
  // Clock and bench commands
  input  wire logic       clk,
  input  wire logic [5:0] cmd,
  // Port side
  input  wire logic       ser_d2a_tx,
  output logic            ser_a2d_rx,
  output logic            net_carrier,
  output logic            net_partner_ok,
  output logic            net_rx_act,
  output pls_pkg::pls_speed_t net_partner_spd
);
  import pls_pkg::*;
  logic [5:0] hold;
  logic       got_bit;
  initial
  begin
    {ser_a2d_rx, net_carrier, net_partner_ok, net_rx_act} = 4'b1000;
    net_partner_spd = PLS_SPD_10;
  end
  // ==========================================================================
  // Lanes and PHY status
  // ==========================================================================
  always @(posedge clk)
  begin
    hold = cmd;
    got_bit = ser_d2a_tx;
    #1;
    ser_a2d_rx = hold[0];
    net_carrier = hold[1];
    net_partner_ok = hold[2];
    net_rx_act = hold[3];
    net_partner_spd = pls_speed_t'(hold[5:4]);
  end
endmodule

// ---- sim/port_link_lamp_status_test.sv ----
// Self-checking bench for the port link and lamp status block.
// Assumes the far model for the PHY and serial partner; one 25 MHz clock.
`timescale 1ns/100ps
module port_link_lamp_status_test;
  import pls_pkg::*;
  logic       clk, rst_b, tx_d, crossed, tx_act, both, live;
  logic       a2d, carrier, ok, rx_act, d2a, rx_d, fp_oe, sp_oe, up, l_l, t_l;
  pls_speed_t p_spd, l_max, spd;
  logic [5:0] cmd, s;
  int         err_total, n_checks, k;
  integer     seed;

  pls_port_top dut (.clk(clk), .rst_b(rst_b), .ser_a2d_rx(a2d),
    .ser_d2a_tx(d2a), .ser_rx_data(rx_d), .ser_tx_data(tx_d),
    .net_crossed(crossed), .net_partner_ok(ok), .net_partner_spd(p_spd),
    .net_local_max(l_max), .net_carrier(carrier), .net_tx_act(tx_act),
    .net_rx_act(rx_act), .lamp_both(both), .first_pair_oe(fp_oe),
    .second_pair_oe(sp_oe), .link_up(up), .link_speed(spd),
    .link_lamp(l_l), .traffic_lamp(t_l));
  pls_far_model far (.clk(clk), .cmd(cmd), .ser_d2a_tx(d2a),
    .ser_a2d_rx(a2d), .net_carrier(carrier), .net_partner_ok(ok),
    .net_rx_act(rx_act), .net_partner_spd(p_spd));

  always #20 clk = ~clk;

  task automatic check(input string what, input logic [2:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // The blink half period is far longer than the run, so the phase never
  // leaves its start value of 1 and an active lamp reads steadily on.
  function automatic logic [2:0] lamps(input logic car, act, two);
    lamps = car ? {2'b01, two & act} : 3'b000;
  endfunction

  // ==========================================================================
  // Per-cycle checks against the inputs seen at the last edge
  // ==========================================================================
  always @(negedge clk)
  begin
    if (live)
    begin
      check("ser_rx_data", rx_d, s[0]);
      check("ser_d2a_tx", d2a, s[1]);
      check("pair_oe", {fp_oe, sp_oe}, {!s[2], s[2]});
      check("lamps", {l_l, t_l}, lamps(s[3], s[4], s[5]));
    end
    s = {both, tx_act | rx_act, carrier, crossed, tx_d, a2d};
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    seed = 32'h9f07_67a7;
    {clk, rst_b, tx_d, crossed, tx_act, both, live} = 7'h00;
    l_max = PLS_SPD_10;
    cmd = 6'h00;
    repeat (8) @(posedge clk);
    #1;
    check("reset_lines", {d2a, rx_d, fp_oe}, 3'b110);
    check("reset_status", {sp_oe, up, l_l}, 3'b000);
    $display("test reset values done");
    repeat (8) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    live = 1'b1;
    repeat (400)
    begin
      @(posedge clk);
      #1;
      {tx_d, crossed, both, tx_act} = 4'($random(seed));
      cmd[3:0] = 4'($random(seed));
    end
    $display("test random lanes and lamps done");
    for (int i = 0; i < 9; i++)
    begin
      @(posedge clk);
      #1;
      cmd = 6'h00;
      l_max = pls_speed_t'(i % 3);
      repeat (4) @(posedge clk);
      #1;
      check("link_drop", up, 1'b0);
      cmd = {2'(i / 3), 4'b0010};
      repeat (4) @(posedge clk);
      #1;
      check("link_wait", up, 1'b0);
      cmd[2] = 1'b1;
      k = 0;
      while (up !== 1'b1 && k < 8)
      begin
        @(negedge clk);
        k++;
      end
      // A hung link counts once and falls through to the closing report.
      if (k == 8)
      begin
        err_total++;
        break;
      end
      // One negedge before the far model's edge, one edge for the far model, one for NEG to UP, one for link_up.
      check("link_time", 3'(k), 3'd4);
      check("link_speed", spd, 3'((i % 3 < i / 3) ? i % 3 : i / 3));
    end
    $display("test autonegotiation done");
    wrap_up();
  end
endmodule
